// *** core/ipl_pkg.sv ***
package ipl_pkg;

	localparam int unsigned NUM_REGS   = 5;
	localparam int unsigned FIELDS     = 8;
	localparam int unsigned NUM_SLOTS  = NUM_REGS * FIELDS;
	localparam int unsigned ADDR_W     = 5;
	localparam int unsigned DATA_W     = 16;
	localparam int unsigned CODE_W     = 2;

	typedef logic [DATA_W-1:0] ipl_word_t;
	typedef logic [ADDR_W-1:0] ipl_addr_t;
	typedef logic [CODE_W-1:0] ipl_code_t;

	// Register index order: debug, core, port/can, serial, decoder/uart
	localparam int unsigned REG_DEBUG  = 0;
	localparam int unsigned REG_CORE   = 1;
	localparam int unsigned REG_PORT   = 2;
	localparam int unsigned REG_SERIAL = 3;
	localparam int unsigned REG_DEC    = 4;

	localparam ipl_addr_t DEBUG_SRC_PRIORITY_OFF    = 5'h01;
	localparam ipl_addr_t CORE_SRC_PRIORITY_B_OFF   = 5'h02;
	localparam ipl_addr_t PORT_CAN_PRIORITY_OFF     = 5'h03;
	localparam ipl_addr_t SERIAL_PORT_PRIORITY_OFF  = 5'h04;
	localparam ipl_addr_t DECODER_UART_PRIORITY_OFF = 5'h05;

	localparam ipl_addr_t REG_OFF [NUM_REGS] = '{
		DEBUG_SRC_PRIORITY_OFF, CORE_SRC_PRIORITY_B_OFF, PORT_CAN_PRIORITY_OFF,
		SERIAL_PORT_PRIORITY_OFF, DECODER_UART_PRIORITY_OFF};

	// Implemented bits; zeros are reserved
	localparam ipl_word_t REG_MASK [NUM_REGS] = '{
		16'h003f, 16'hffcf, 16'hfffc, 16'hfc3f, 16'hff3f};

	localparam ipl_word_t REG_RESET = 16'h0000;
	localparam ipl_code_t CODE_DISABLED = 2'h0;
	localparam ipl_code_t LEVEL_STEP    = 2'h1;

	// Slot = register index * 8 + field position (bits 2f+1:2f)
	localparam int unsigned SLOT_DEBUG_TRACE_BUFFER = 0;
	localparam int unsigned SLOT_DEBUG_TX_EMPTY     = 1;
	localparam int unsigned SLOT_DEBUG_RX_FULL      = 2;
	localparam int unsigned SLOT_EXT_PIN_A          = 8;
	localparam int unsigned SLOT_EXT_PIN_B          = 9;
	localparam int unsigned SLOT_LOW_VOLTAGE        = 11;
	localparam int unsigned SLOT_PLL_LOST_SYNC      = 12;
	localparam int unsigned SLOT_FLASH_FAULT        = 13;
	localparam int unsigned SLOT_FLASH_CMD_DONE     = 14;
	localparam int unsigned SLOT_FLASH_BUF_EMPTY    = 15;
	localparam int unsigned SLOT_CAN_BUS_OFF        = 17;
	localparam int unsigned SLOT_CAN_FAULT          = 18;
	localparam int unsigned SLOT_CAN_WAKE           = 19;
	localparam int unsigned SLOT_CAN_MSG_BUFFER     = 20;
	localparam int unsigned SLOT_PORT_F             = 21;
	localparam int unsigned SLOT_PORT_E             = 22;
	localparam int unsigned SLOT_PORT_D             = 23;
	localparam int unsigned SLOT_PORT_C             = 24;
	localparam int unsigned SLOT_PORT_B             = 25;
	localparam int unsigned SLOT_PORT_A             = 26;
	localparam int unsigned SLOT_SPI_PORT1_RX_FULL  = 29;
	localparam int unsigned SLOT_SPI_PORT1_TX_EMPTY = 30;
	localparam int unsigned SLOT_SPI_PORT0_RX_FULL  = 31;
	localparam int unsigned SLOT_SPI_PORT0_TX_EMPTY = 32;
	localparam int unsigned SLOT_UART_TX_EMPTY      = 33;
	localparam int unsigned SLOT_UART_TX_IDLE       = 34;
	localparam int unsigned SLOT_UART_RX_ERROR      = 36;
	localparam int unsigned SLOT_UART_RX_FULL       = 37;
	localparam int unsigned SLOT_DECODER1_HOME      = 38;
	localparam int unsigned SLOT_DECODER1_INDEX     = 39;

endpackage

// *** core/ipl_field_decode.sv ***
module ipl_field_decode
	import ipl_pkg::*;
(
	input  wire ipl_pkg::ipl_code_t code,
	input  wire logic               debug_scale,
	output logic                    enable,
	output ipl_pkg::ipl_code_t      level
);
	import ipl_pkg::*;

	always_comb begin
		enable = (code != CODE_DISABLED);
		// Debug codes map 1..3 directly; others are shifted down to 0..2
		if (debug_scale) begin
			level = code;
		end else if (enable) begin
			level = code - LEVEL_STEP;
		end else begin
			level = CODE_DISABLED;
		end
	end
endmodule

// *** core/ipl_priority_regs.sv ***
module ipl_priority_regs
	import ipl_pkg::*;
(
	input  wire logic                      mclk,
	input  wire logic                      rst,
	input  wire ipl_pkg::ipl_addr_t        bus_addr,
	input  wire ipl_pkg::ipl_word_t        bus_wdata,
	input  wire logic                      bus_we,
	input  wire logic                      bus_re,
	output ipl_pkg::ipl_word_t             bus_rdata,
	output logic [ipl_pkg::NUM_SLOTS-1:0]  src_enable,
	output logic [2*ipl_pkg::NUM_SLOTS-1:0] src_level,
	input  wire logic                      low_power,
	input  wire logic [ipl_pkg::NUM_SLOTS-1:0] src_request,
	output logic                           wake_req
);
	import ipl_pkg::*;

	ipl_word_t                regs_q [NUM_REGS];
	ipl_word_t                rdata_q;
	logic [NUM_REGS-1:0]      hit;
	logic                     lp_q;
	logic [NUM_SLOTS-1:0]     wake_en_q;
	logic                     wake_q;

	always_comb begin
		for (int i = 0; i < NUM_REGS; i++) begin
			hit[i] = (bus_addr == REG_OFF[i]);
		end
	end

	// Register writes; only implemented bits are stored
	always_ff @(posedge mclk) begin
		for (int i = 0; i < NUM_REGS; i++) begin
			if (rst) begin
				regs_q[i] <= REG_RESET;
			end else if (bus_we && hit[i]) begin
				regs_q[i] <= bus_wdata & REG_MASK[i];
			end
		end
	end

	// Read data for one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q <= REG_RESET;
		end else begin
			rdata_q <= REG_RESET;
			if (bus_re) begin
				for (int i = 0; i < NUM_REGS; i++) begin
					if (hit[i]) begin
						rdata_q <= regs_q[i] & REG_MASK[i];
					end
				end
			end
		end
	end

	assign bus_rdata = rdata_q;

	// Field slots: bits 2f+1:2f of each register, debug register scaled 1..3
	for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
		for (genvar f = 0; f < FIELDS; f++) begin : g_fld
			ipl_field_decode u_dec (
				.code        (regs_q[r][CODE_W*f+:CODE_W]),
				.debug_scale (r == REG_DEBUG),
				.enable      (src_enable[r*FIELDS+f]),
				.level       (src_level[CODE_W*(r*FIELDS+f)+:CODE_W])
			);
		end
	end

	// Capture enables as the device enters wait or stop
	always_ff @(posedge mclk) begin
		if (rst) begin
			lp_q      <= 1'b0;
			wake_en_q <= '0;
		end else begin
			lp_q <= low_power;
			if (low_power && !lp_q) begin
				wake_en_q <= src_enable;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= low_power && lp_q && |(src_request & wake_en_q);
		end
	end

	assign wake_req = wake_q;

	// Checks
	sequence s_read(ipl_addr_t a);
		bus_re && bus_addr == a;
	endsequence

	sequence s_write(ipl_addr_t a);
		bus_we && bus_addr == a;
	endsequence

	property p_debug_decode;
		@(posedge mclk) disable iff (rst)
		src_enable[SLOT_DEBUG_RX_FULL] |->
			src_level[2*SLOT_DEBUG_RX_FULL+:2] == regs_q[REG_DEBUG][5:4];
	endproperty
	a_debug_decode: assert property (p_debug_decode)
		else $error("debug level not equal to field code");

	property p_periph_decode;
		@(posedge mclk) disable iff (rst)
		src_enable[SLOT_EXT_PIN_A] |->
			src_level[2*SLOT_EXT_PIN_A+:2] == regs_q[REG_CORE][1:0] - LEVEL_STEP;
	endproperty
	a_periph_decode: assert property (p_periph_decode)
		else $error("peripheral level not one below field code");

	property p_reset_clear;
		@(posedge mclk) disable iff (rst)
		$fell(rst) |-> (src_enable == '0) && (bus_rdata == REG_RESET);
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("source enabled right after reset");

	property p_reserved_read;
		@(posedge mclk) disable iff (rst)
		s_read(CORE_SRC_PRIORITY_B_OFF) |=> bus_rdata[5:4] == 2'h0;
	endproperty
	a_reserved_read: assert property (p_reserved_read)
		else $error("reserved bits read nonzero");

	property p_debug_layout;
		@(posedge mclk) disable iff (rst)
		s_write(DEBUG_SRC_PRIORITY_OFF) ##1 !bus_we [*2] |->
			src_enable[SLOT_DEBUG_TX_EMPTY] == ($past(bus_wdata[3:2], 2) != 2'h0);
	endproperty
	a_debug_layout: assert property (p_debug_layout)
		else $error("debug tx-empty field misplaced");

	property p_core_write;
		@(posedge mclk) disable iff (rst)
		s_write(CORE_SRC_PRIORITY_B_OFF) |=>
			src_enable[SLOT_FLASH_BUF_EMPTY] == ($past(bus_wdata[15:14]) != 2'h0);
	endproperty
	a_core_write: assert property (p_core_write)
		else $error("flash field did not follow write");

	property p_port_reserved;
		@(posedge mclk) disable iff (rst)
		s_write(PORT_CAN_PRIORITY_OFF) ##1 s_read(PORT_CAN_PRIORITY_OFF) |=>
			bus_rdata == ($past(bus_wdata, 2) & 16'hfffc);
	endproperty
	a_port_reserved: assert property (p_port_reserved)
		else $error("port register readback wrong");

	property p_serial_mask;
		@(posedge mclk) disable iff (rst)
		s_write(SERIAL_PORT_PRIORITY_OFF) |=>
			regs_q[REG_SERIAL] == ($past(bus_wdata) & 16'hfc3f);
	endproperty
	a_serial_mask: assert property (p_serial_mask)
		else $error("serial register stored reserved bits");

	property p_wake_gate;
		@(posedge mclk) disable iff (rst)
		wake_req |-> $past(low_power) && |($past(src_request) & $past(wake_en_q));
	endproperty
	a_wake_gate: assert property (p_wake_gate)
		else $error("wake from a disabled source");

	property p_read_latency;
		@(posedge mclk) disable iff (rst)
		s_read(DECODER_UART_PRIORITY_OFF) ##1 !bus_re |=> bus_rdata == REG_RESET;
	endproperty
	a_read_latency: assert property (p_read_latency)
		else $error("read data held beyond one cycle");

	property p_debug_floor;
		@(posedge mclk) disable iff (rst)
		src_enable[SLOT_DEBUG_TRACE_BUFFER] |->
			src_level[2*SLOT_DEBUG_TRACE_BUFFER+:2] != CODE_DISABLED;
	endproperty
	a_debug_floor: assert property (p_debug_floor)
		else $error("debug source given level zero");

	property p_debug_tx_decode;
		@(posedge mclk) disable iff (rst)
		src_enable[SLOT_DEBUG_TX_EMPTY] |->
			src_level[2*SLOT_DEBUG_TX_EMPTY+:2] == regs_q[REG_DEBUG][3:2];
	endproperty
	a_debug_tx_decode: assert property (p_debug_tx_decode)
		else $error("debug tx-empty level not equal to field code");

	property p_periph_ceiling;
		@(posedge mclk) disable iff (rst)
		src_enable[SLOT_LOW_VOLTAGE] |->
			src_level[2*SLOT_LOW_VOLTAGE+:2] != 2'h3;
	endproperty
	a_periph_ceiling: assert property (p_periph_ceiling)
		else $error("peripheral source reached level three");

	property p_port_d_decode;
		@(posedge mclk) disable iff (rst)
		src_enable[SLOT_PORT_D] |->
			src_level[2*SLOT_PORT_D+:2] == regs_q[REG_PORT][15:14] - LEVEL_STEP;
	endproperty
	a_port_d_decode: assert property (p_port_d_decode)
		else $error("port d level not one below field code");

	property p_periph_off;
		@(posedge mclk) disable iff (rst)
		!src_enable[SLOT_PORT_A] |->
			src_level[2*SLOT_PORT_A+:2] == CODE_DISABLED;
	endproperty
	a_periph_off: assert property (p_periph_off)
		else $error("disabled source shows a level");

	property p_reset_levels;
		@(posedge mclk) disable iff (rst)
		$fell(rst) |->
			(src_level == '0) && !wake_req;
	endproperty
	a_reset_levels: assert property (p_reset_levels)
		else $error("level or wake left set by reset");

	// Slots with no field behind them
	property p_reserved_slots;
		@(posedge mclk) disable iff (rst)
		(src_enable & 40'h08_1801_04f8) == '0;
	endproperty
	a_reserved_slots: assert property (p_reserved_slots)
		else $error("reserved slot enabled");

	property p_unmapped_read;
		@(posedge mclk) disable iff (rst)
		bus_re && (hit == '0) |=>
			bus_rdata == REG_RESET;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped read returned nonzero");

	property p_reserved_dec;
		@(posedge mclk) disable iff (rst)
		s_read(DECODER_UART_PRIORITY_OFF) |=>
			bus_rdata[7:6] == 2'h0;
	endproperty
	a_reserved_dec: assert property (p_reserved_dec)
		else $error("decoder register reserved bits read nonzero");

	property p_reserved_debug;
		@(posedge mclk) disable iff (rst)
		s_read(DEBUG_SRC_PRIORITY_OFF) |=>
			bus_rdata[15:6] == 10'h000;
	endproperty
	a_reserved_debug: assert property (p_reserved_debug)
		else $error("debug register upper bits read nonzero");

	property p_trace_layout;
		@(posedge mclk) disable iff (rst)
		s_write(DEBUG_SRC_PRIORITY_OFF) |=>
			src_enable[SLOT_DEBUG_TRACE_BUFFER] == ($past(bus_wdata[1:0]) != 2'h0);
	endproperty
	a_trace_layout: assert property (p_trace_layout)
		else $error("debug trace buffer field misplaced");

	property p_pin_b_layout;
		@(posedge mclk) disable iff (rst)
		s_write(CORE_SRC_PRIORITY_B_OFF) |=>
			src_enable[SLOT_EXT_PIN_B] == ($past(bus_wdata[3:2]) != 2'h0);
	endproperty
	a_pin_b_layout: assert property (p_pin_b_layout)
		else $error("pin b field misplaced");

	property p_can_wake_layout;
		@(posedge mclk) disable iff (rst)
		s_write(PORT_CAN_PRIORITY_OFF) |=>
			src_enable[SLOT_CAN_WAKE] == ($past(bus_wdata[7:6]) != 2'h0);
	endproperty
	a_can_wake_layout: assert property (p_can_wake_layout)
		else $error("can wake field misplaced");

	property p_reserved_port;
		@(posedge mclk) disable iff (rst)
		s_read(PORT_CAN_PRIORITY_OFF) |=>
			bus_rdata[1:0] == 2'h0;
	endproperty
	a_reserved_port: assert property (p_reserved_port)
		else $error("port register low bits read nonzero");

	property p_spi0_layout;
		@(posedge mclk) disable iff (rst)
		s_write(SERIAL_PORT_PRIORITY_OFF) |=>
			src_enable[SLOT_SPI_PORT0_RX_FULL] == ($past(bus_wdata[15:14]) != 2'h0);
	endproperty
	a_spi0_layout: assert property (p_spi0_layout)
		else $error("spi port 0 field misplaced");

	property p_reserved_serial;
		@(posedge mclk) disable iff (rst)
		s_read(SERIAL_PORT_PRIORITY_OFF) |=>
			bus_rdata[9:6] == 4'h0;
	endproperty
	a_reserved_serial: assert property (p_reserved_serial)
		else $error("serial register middle bits read nonzero");

	property p_wake_awake;
		@(posedge mclk) disable iff (rst)
		!low_power |=>
			!wake_req;
	endproperty
	a_wake_awake: assert property (p_wake_awake)
		else $error("wake request outside low power");

	property p_wake_entry;
		@(posedge mclk) disable iff (rst)
		low_power && !lp_q |=>
			!wake_req;
	endproperty
	a_wake_entry: assert property (p_wake_entry)
		else $error("wake request before enables were captured");

	property p_write_effect;
		@(posedge mclk) disable iff (rst)
		s_write(DECODER_UART_PRIORITY_OFF) |=>
			regs_q[REG_DEC] == ($past(bus_wdata) & REG_MASK[REG_DEC]);
	endproperty
	a_write_effect: assert property (p_write_effect)
		else $error("decoder register did not take the write");

	property p_hold;
		@(posedge mclk) disable iff (rst)
		!bus_we && !rst |=>
			$stable(src_enable);
	endproperty
	a_hold: assert property (p_hold)
		else $error("enables changed without a write");

endmodule

// *** verif/tb.sv ***
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ipl_pkg::*;

	logic                   mclk = 1'b0;
	logic                   rst = 1'b1;
	logic                   bus_we = 1'b0;
	logic                   bus_re = 1'b0;
	logic                   low_power = 1'b0;
	ipl_addr_t              bus_addr = 5'h00;
	ipl_word_t              bus_wdata = 16'h0000;
	ipl_word_t              bus_rdata;
	ipl_word_t              w;
	logic [NUM_SLOTS-1:0]   src_enable;
	logic [NUM_SLOTS-1:0]   src_request = '0;
	logic [2*NUM_SLOTS-1:0] src_level;
	logic                   wake_req;
	int                     num_errors = 0;
	int                     n_checks = 0;
	int                     cycles = 0;
	// Implemented bits per register, debug register first
	ipl_word_t              impl_bits [5] = '{16'h003f, 16'hffcf, 16'hfffc, 16'hfc3f, 16'hff3f};

	ipl_priority_regs dut (
		.mclk       (mclk),
		.rst        (rst),
		.bus_addr   (bus_addr),
		.bus_wdata  (bus_wdata),
		.bus_we     (bus_we),
		.bus_re     (bus_re),
		.bus_rdata  (bus_rdata),
		.src_enable (src_enable),
		.src_level  (src_level),
		.low_power  (low_power),
		.src_request(src_request),
		.wake_req   (wake_req)
	);

	initial begin
		forever #50 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Called just after a rising edge; the strobe is taken at the next edge
	task automatic wr(input ipl_addr_t a, input ipl_word_t d);
		bus_we    <= 1'b1;
		bus_addr  <= a;
		bus_wdata <= d;
		@(posedge mclk);
		bus_we <= 1'b0;
		@(posedge mclk);
	endtask

	// Read data are taken in the single cycle after the strobe
	task automatic rd(input ipl_addr_t a, output ipl_word_t d);
		bus_re   <= 1'b1;
		bus_addr <= a;
		@(posedge mclk);
		bus_re <= 1'b0;
		@(posedge mclk);
		d = bus_rdata;
	endtask

	// Write, then read the same offset with no gap
	task automatic wr_rd(input ipl_addr_t a, input ipl_word_t d, output ipl_word_t q);
		bus_we    <= 1'b1;
		bus_addr  <= a;
		bus_wdata <= d;
		@(posedge mclk);
		bus_we <= 1'b0;
		bus_re <= 1'b1;
		@(posedge mclk);
		bus_re <= 1'b0;
		@(posedge mclk);
		q = bus_rdata;
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		chk(src_enable, 0);
		chk(src_level, 0);
		for (int i = 0; i < 5; i++) begin
			rd(REG_OFF[i], w);
			chk(w, 16'h0000);
		end
		$display("test reset done");
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		do_reset();
		for (int i = 0; i < 5; i++) begin
			wr(REG_OFF[i], 16'hffff);
			rd(REG_OFF[i], w);
			chk(w, impl_bits[i]);
		end
		@(posedge mclk);
		chk(bus_rdata, 16'h0000);
		wr_rd(REG_OFF[2], 16'h5a5a, w);
		chk(w, 16'h5a58);
		wr(5'h00, 16'hffff);
		rd(5'h00, w);
		chk(w, 16'h0000);
		rd(5'h06, w);
		chk(w, 16'h0000);
		$display("test register map done");
		for (int i = 0; i < 5; i++) begin
			wr(REG_OFF[i], 16'h0000);
		end
		// Debug codes 11/10/01, then pin A 01, pin B 10, low voltage 11
		wr(REG_OFF[0], 16'h001b);
		chk(src_enable, 40'h7);
		chk(src_level, 80'h1b);
		wr(REG_OFF[1], 16'h00c9);
		chk(src_enable, 40'hb07);
		chk(src_level, 80'h84001b);
		$display("test decode done");
		low_power <= 1'b1;
		src_request[13] <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(wake_req, 1'b0);
		wr(REG_OFF[1], 16'h04c9);
		repeat (3) @(posedge mclk);
		chk(wake_req, 1'b0);
		src_request[8] <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(wake_req, 1'b1);
		low_power <= 1'b0;
		src_request <= '0;
		repeat (3) @(posedge mclk);
		chk(wake_req, 1'b0);
		$display("test wake done");
		do_reset();
		report_and_stop();
	end
endmodule
